// [verilog/mmb_pkg.sv]
// Purpose: Shared constants and types of the memory map bank decoder
// Assumes: 32-bit AHB-Lite register access, one word per file location
// Notes:   File offsets are indices; the byte address is four times them
`default_nettype none
package mmb_pkg;

	// Program store
	localparam int              PC_W           = 13;
	localparam int              WORD_W         = 14;
	localparam int              PROG_WORDS_MAX = 8192;
	localparam int              PROG_WORDS_MIN = 4096;
	localparam logic [12:0]     RESET_VEC      = 13'h0000;
	localparam logic [12:0]     IRQ_VEC        = 13'h0004;
	localparam logic [12:0]     PC_INC         = 13'h0001;
	localparam int              LATCH_USED     = 5;

	// File address layout
	localparam int              FILE_W         = 9;
	localparam int              OFS_W          = 7;
	localparam int              ST_IND_BANK    = 7;
	localparam int              ST_BANK_HI     = 6;
	localparam int              ST_BANK_LO     = 5;

	// In-bank offsets of the core registers, mirrored in every bank
	localparam logic [6:0]      OFS_INDIRECT   = 7'h00;
	localparam logic [6:0]      OFS_PC_LOW     = 7'h02;
	localparam logic [6:0]      OFS_STATUS     = 7'h03;
	localparam logic [6:0]      OFS_FILE_PTR   = 7'h04;
	localparam logic [6:0]      OFS_PC_LATCH   = 7'h0a;

	// Program store read-back registers, bank 2 only
	localparam logic [1:0]      PRG_BANK       = 2'h2;
	localparam logic [6:0]      OFS_PRD_LO     = 7'h0c;
	localparam logic [6:0]      OFS_PRA_LO     = 7'h0d;
	localparam logic [6:0]      OFS_PRD_HI     = 7'h0e;
	localparam logic [6:0]      OFS_PRA_HI     = 7'h0f;

	// General purpose RAM layout
	localparam logic [6:0]      OFS_GPR_BASE   = 7'h20;
	localparam logic [6:0]      OFS_COMMON     = 7'h70;
	localparam logic [8:0]      GPR_BANK0_SIZE = 9'h060;
	localparam logic [8:0]      GPR_BANKN_SIZE = 9'h050;
	localparam int              GPR_DEPTH      = 336;

	// Reset values
	localparam logic [7:0]      STATUS_RST     = 8'h00;
	localparam logic [7:0]      PTR_RST        = 8'h00;
	localparam logic [7:0]      LATCH_RST      = 8'h00;
	localparam logic [7:0]      PRA_RST        = 8'h00;

	// AHB-Lite
	localparam logic            HRESP_OKAY     = 1'b0;
	localparam logic [2:0]      HSIZE_WORD     = 3'h2;
	localparam int              HADDR_MAP_W    = 9;

	typedef enum logic [1:0] {
		BUS_IDLE   = 2'b00,
		BUS_WRITE  = 2'b01,
		BUS_RDWAIT = 2'b10,
		BUS_RDDATA = 2'b11
	} mmb_bus_state_t;

	typedef enum logic [3:0] {
		LOC_NONE     = 4'b0000,
		LOC_PC_LOW   = 4'b0001,
		LOC_STATUS   = 4'b0010,
		LOC_FILE_PTR = 4'b0011,
		LOC_PC_LATCH = 4'b0100,
		LOC_PRD_LO   = 4'b0101,
		LOC_PRA_LO   = 4'b0110,
		LOC_PRD_HI   = 4'b0111,
		LOC_PRA_HI   = 4'b1000,
		LOC_GPR      = 4'b1001
	} mmb_loc_t;

endpackage
`default_nettype wire

// [verilog/mmb_pc.sv]
// Purpose: Program counter and fetch address with wraparound
// Assumes: Step, vector and load requests come from the core clock domain
// Notes:   Vector beats load, load beats step
`timescale 1ns/1ps
`default_nettype none
module mmb_pc #(
	parameter int PROG_WORDS = mmb_pkg::PROG_WORDS_MAX
) (
	// Clock and reset
	input  wire logic                     clk,
	input  wire logic                     rst_n,
	// Requests
	input  wire logic                     step,
	input  wire logic                     irq_take,
	input  wire logic                     load,
	input  wire logic [mmb_pkg::PC_W-1:0] load_val,
	// State
	output logic      [mmb_pkg::PC_W-1:0] pc_q,
	output logic      [mmb_pkg::PC_W-1:0] fetch_addr
);

	localparam logic [mmb_pkg::PC_W-1:0] MASK =
		mmb_pkg::PC_W'(PROG_WORDS - 1);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pc_q <= mmb_pkg::RESET_VEC;
		end else if (irq_take) begin
			pc_q <= mmb_pkg::IRQ_VEC;
		end else if (load) begin
			pc_q <= load_val;
		end else if (step) begin
			pc_q <= pc_q + mmb_pkg::PC_INC;
		end
	end

	// Upper bits above the fitted store are dropped, so fetches alias
	assign fetch_addr = pc_q & MASK;

	chk_irq_vector: assert property (
		@(posedge clk) disable iff (!rst_n)
		irq_take |=> pc_q == mmb_pkg::IRQ_VEC)
		else $error("interrupt did not vector");

	chk_reset_vector: assert property (
		@(posedge clk) disable iff (!rst_n)
		$rose(rst_n) |-> pc_q == mmb_pkg::RESET_VEC)
		else $error("program counter not at reset vector");

	chk_pc_step: assert property (
		@(posedge clk) disable iff (!rst_n)
		(step && !irq_take && !load)
		|=> pc_q == $past(pc_q) + mmb_pkg::PC_INC)
		else $error("program counter did not advance");

	chk_fetch_wrap: assert property (
		@(posedge clk) disable iff (!rst_n)
		32'(fetch_addr) < PROG_WORDS)
		else $error("fetch beyond implemented store");

endmodule
`default_nettype wire

// [verilog/mmb_gpr_ram.sv]
// Purpose: General purpose static RAM of the register file
// Assumes: One write and one read port, index already folded by banks
// Notes:   Contents are not cleared by reset
`timescale 1ns/1ps
`default_nettype none
module mmb_gpr_ram #(
	parameter int DEPTH = mmb_pkg::GPR_DEPTH,
	parameter int WIDTH = 8,
	parameter int AW    = mmb_pkg::FILE_W
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst_n,
	// Write port
	input  wire logic             we,
	input  wire logic [AW-1:0]    waddr,
	input  wire logic [WIDTH-1:0] wdata,
	// Read port
	input  wire logic [AW-1:0]    raddr,
	output logic      [WIDTH-1:0] rdata
);

	logic [WIDTH-1:0] mem_q [DEPTH];

	always_ff @(posedge clk) begin
		if (we && waddr < AW'(DEPTH)) begin
			mem_q[waddr] <= wdata;
		end
	end

	assign rdata = (raddr < AW'(DEPTH)) ? mem_q[raddr] : '0;

	chk_ram_store: assert property (
		@(posedge clk) disable iff (!rst_n)
		(we && waddr < AW'(DEPTH))
		|=> mem_q[$past(waddr)] == $past(wdata))
		else $error("RAM write not stored");

endmodule
`default_nettype wire

// [verilog/mmb_bank_decoder.sv]
// Purpose: Banked register file map, program counter and fetch port
// Assumes: AHB-Lite master of single word transfers; core on hclk
// Notes:   Word index on haddr[8:2] is the in-bank offset of a direct
//          access; reads take one wait state, writes none
//
// Contract
// - Fetch and data access run independently
// - User code reads program store words
// - 13-bit counter over 8K 14-bit words
// - 8K or 4K store, fetches wrap around
// - Reset to 0000h, interrupt to 0004h
// - Status bits 6:5 select bank 0..3
// - Each bank spans 128 direct offsets
// - Core registers low, static RAM above
// - Mirrored registers reach one physical copy
// - Access direct or via file pointer
// - Unimplemented locations read as zero
//
// The AHB-Lite register port was chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module mmb_bank_decoder #(
	parameter int PROG_WORDS = mmb_pkg::PROG_WORDS_MAX
) (
	// Clock and reset
	input  wire logic                       hclk,
	input  wire logic                       hresetn,
	// AHB-Lite slave
	input  wire logic                       hsel,
	input  wire logic [31:0]                haddr,
	input  wire logic [1:0]                 htrans,
	input  wire logic                       hwrite,
	input  wire logic [2:0]                 hsize,
	input  wire logic [31:0]                hwdata,
	input  wire logic                       hready,
	output logic                            hreadyout,
	output logic      [31:0]                hrdata,
	output logic                            hresp,
	// Core sequencing
	input  wire logic                       core_step,
	input  wire logic                       core_irq_take,
	// Program fetch bus
	output logic      [mmb_pkg::PC_W-1:0]   fetch_addr,
	input  wire logic [mmb_pkg::WORD_W-1:0] fetch_word,
	output logic      [mmb_pkg::WORD_W-1:0] instr_q,
	// Program read-back port
	output logic      [mmb_pkg::PC_W-1:0]   prog_rd_addr,
	input  wire logic [mmb_pkg::WORD_W-1:0] prog_rd_word,
	// Visible state
	output logic      [1:0]                 bank_select
);

	localparam logic [mmb_pkg::PC_W-1:0] PMASK =
		mmb_pkg::PC_W'(PROG_WORDS - 1);

	mmb_pkg::mmb_bus_state_t state_q;

	logic                       accept;
	logic [6:0]                 ofs_q;
	logic                       bad_q;
	logic [8:0]                 acc_file;
	mmb_pkg::mmb_loc_t          acc_loc;
	logic                       wr_en;
	logic [7:0]                 wdat;
	logic [7:0]                 rd_val;
	logic [7:0]                 hrd_q;
	logic [7:0]                 status_q;
	logic [7:0]                 file_ptr_q;
	logic [7:0]                 pc_latch_q;
	logic [7:0]                 pra_lo_q;
	logic [7:0]                 pra_hi_q;
	logic [mmb_pkg::WORD_W-1:0] prd_q;
	logic [mmb_pkg::PC_W-1:0]   pc_q;
	logic                       pc_load;
	logic [mmb_pkg::PC_W-1:0]   pc_load_val;
	logic [8:0]                 gpr_idx;
	logic [7:0]                 gpr_rdata;
	logic                       gpr_we;

	// Effective file address: bank bits over offset, or the pointer
	function automatic logic [8:0] eff_file(
		input logic [6:0] ofs,
		input logic [7:0] st,
		input logic [7:0] ptr
	);
		if (ofs == mmb_pkg::OFS_INDIRECT) begin
			eff_file = {st[mmb_pkg::ST_IND_BANK], ptr};
		end else begin
			eff_file = {st[mmb_pkg::ST_BANK_HI],
				st[mmb_pkg::ST_BANK_LO], ofs};
		end
	endfunction

	// What physical thing a file address reaches
	function automatic mmb_pkg::mmb_loc_t loc_of(input logic [8:0] f);
		logic [6:0] ofs;
		logic [1:0] bank;
		ofs    = f[6:0];
		bank   = f[8:7];
		loc_of = mmb_pkg::LOC_NONE;
		// Core register offsets land on the same register in each bank; 0Ch..0Fh only in bank 2
		case (ofs)
			mmb_pkg::OFS_PC_LOW:   loc_of = mmb_pkg::LOC_PC_LOW;
			mmb_pkg::OFS_STATUS:   loc_of = mmb_pkg::LOC_STATUS;
			mmb_pkg::OFS_FILE_PTR: loc_of = mmb_pkg::LOC_FILE_PTR;
			mmb_pkg::OFS_PC_LATCH: loc_of = mmb_pkg::LOC_PC_LATCH;
			mmb_pkg::OFS_PRD_LO: begin
				if (bank == mmb_pkg::PRG_BANK) begin
					loc_of = mmb_pkg::LOC_PRD_LO;
				end
			end
			mmb_pkg::OFS_PRA_LO: begin
				if (bank == mmb_pkg::PRG_BANK) begin
					loc_of = mmb_pkg::LOC_PRA_LO;
				end
			end
			mmb_pkg::OFS_PRD_HI: begin
				if (bank == mmb_pkg::PRG_BANK) begin
					loc_of = mmb_pkg::LOC_PRD_HI;
				end
			end
			mmb_pkg::OFS_PRA_HI: begin
				if (bank == mmb_pkg::PRG_BANK) begin
					loc_of = mmb_pkg::LOC_PRA_HI;
				end
			end
			default: begin
				if (ofs >= mmb_pkg::OFS_GPR_BASE) begin
					loc_of = mmb_pkg::LOC_GPR;
				end
			end
		endcase
	endfunction

	// Fold banked RAM onto one array; the common top maps to bank 0
	function automatic logic [8:0] gpr_index(input logic [8:0] f);
		logic [6:0] ofs;
		logic [1:0] bank;
		logic [8:0] rel;
		ofs = f[6:0];
		bank = f[8:7];
		rel = {2'h0, 7'(ofs - mmb_pkg::OFS_GPR_BASE)};
		if (bank == 2'h0 || ofs >= mmb_pkg::OFS_COMMON) begin
			gpr_index = rel;
		end else begin
			gpr_index = mmb_pkg::GPR_BANK0_SIZE
				+ 9'({7'h00, 2'(bank - 2'h1)}
				* mmb_pkg::GPR_BANKN_SIZE) + rel;
		end
	endfunction

	// Bus slave
	assign accept = hsel && hready && htrans[1];
	assign hreadyout = (state_q != mmb_pkg::BUS_RDWAIT);
	assign hresp = mmb_pkg::HRESP_OKAY;
	assign hrdata = {24'h000000, hrd_q};

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= mmb_pkg::BUS_IDLE;
		end else begin
			unique case (state_q)
				mmb_pkg::BUS_RDWAIT: begin
					state_q <= mmb_pkg::BUS_RDDATA;
				end
				mmb_pkg::BUS_IDLE,
				mmb_pkg::BUS_WRITE,
				mmb_pkg::BUS_RDDATA: begin
					if (accept) begin
						state_q <= hwrite ? mmb_pkg::BUS_WRITE
							: mmb_pkg::BUS_RDWAIT;
					end else begin
						state_q <= mmb_pkg::BUS_IDLE;
					end
				end
			endcase
		end
	end

	// Only the 128 word indices are mapped; anything else is ignored
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ofs_q <= mmb_pkg::OFS_INDIRECT;
			bad_q <= 1'b0;
		end else if (accept) begin
			ofs_q <= haddr[mmb_pkg::HADDR_MAP_W-1:2];
			bad_q <= (|haddr[31:mmb_pkg::HADDR_MAP_W])
				|| (|haddr[1:0])
				|| (hsize != mmb_pkg::HSIZE_WORD);
		end
	end

	// Bank bits are looked at in the data phase, after earlier writes
	assign acc_file = eff_file(ofs_q, status_q, file_ptr_q);
	assign acc_loc = loc_of(acc_file);
	assign wr_en = (state_q == mmb_pkg::BUS_WRITE) && !bad_q;
	assign wdat = hwdata[7:0];
	assign gpr_idx = gpr_index(acc_file);
	assign gpr_we = wr_en && (acc_loc == mmb_pkg::LOC_GPR);
	assign bank_select = status_q[mmb_pkg::ST_BANK_HI:mmb_pkg::ST_BANK_LO];

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= mmb_pkg::STATUS_RST;
		end else if (wr_en && acc_loc == mmb_pkg::LOC_STATUS) begin
			status_q <= wdat;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			file_ptr_q <= mmb_pkg::PTR_RST;
		end else if (wr_en && acc_loc == mmb_pkg::LOC_FILE_PTR) begin
			file_ptr_q <= wdat;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pc_latch_q <= mmb_pkg::LATCH_RST;
		end else if (wr_en && acc_loc == mmb_pkg::LOC_PC_LATCH) begin
			pc_latch_q <= wdat;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			pra_lo_q <= mmb_pkg::PRA_RST;
			pra_hi_q <= mmb_pkg::PRA_RST;
		end else if (wr_en && acc_loc == mmb_pkg::LOC_PRA_LO) begin
			pra_lo_q <= wdat;
		end else if (wr_en && acc_loc == mmb_pkg::LOC_PRA_HI) begin
			pra_hi_q <= wdat;
		end
	end

	// Writing the low counter byte jumps, upper bits from the latch
	assign pc_load = wr_en && (acc_loc == mmb_pkg::LOC_PC_LOW);
	assign pc_load_val = {pc_latch_q[mmb_pkg::LATCH_USED-1:0], wdat};

	// Read-back uses its own port, so fetches never stall for it
	assign prog_rd_addr = {pra_hi_q[mmb_pkg::LATCH_USED-1:0],
		pra_lo_q} & PMASK;

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			prd_q <= '0;
		end else begin
			prd_q <= prog_rd_word;
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			instr_q <= '0;
		end else begin
			instr_q <= fetch_word;
		end
	end

	// Indirect through the pointer onto itself is not physical
	always_comb begin
		rd_val = 8'h00;
		if (!bad_q) begin
			case (acc_loc)
				mmb_pkg::LOC_PC_LOW:   rd_val = pc_q[7:0];
				mmb_pkg::LOC_STATUS:   rd_val = status_q;
				mmb_pkg::LOC_FILE_PTR: rd_val = file_ptr_q;
				mmb_pkg::LOC_PC_LATCH: rd_val = pc_latch_q;
				mmb_pkg::LOC_PRD_LO: rd_val = prd_q[7:0];
				mmb_pkg::LOC_PRA_LO: rd_val = pra_lo_q;
				mmb_pkg::LOC_PRD_HI: rd_val = {2'h0, prd_q[13:8]};
				mmb_pkg::LOC_PRA_HI: rd_val = pra_hi_q;
				mmb_pkg::LOC_GPR:    rd_val = gpr_rdata;
				default:             rd_val = 8'h00;
			endcase
		end
	end

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			hrd_q <= 8'h00;
		end else if (state_q == mmb_pkg::BUS_RDWAIT) begin
			hrd_q <= rd_val;
		end
	end

	mmb_pc #(
		.PROG_WORDS (PROG_WORDS)
	) u_pc (
		.clk        (hclk),
		.rst_n      (hresetn),
		.step       (core_step),
		.irq_take   (core_irq_take),
		.load       (pc_load),
		.load_val   (pc_load_val),
		.pc_q       (pc_q),
		.fetch_addr (fetch_addr)
	);

	mmb_gpr_ram #(
		.DEPTH (mmb_pkg::GPR_DEPTH),
		.WIDTH (8),
		.AW    (mmb_pkg::FILE_W)
	) u_gpr (
		.clk   (hclk),
		.rst_n (hresetn),
		.we    (gpr_we),
		.waddr (gpr_idx),
		.wdata (wdat),
		.raddr (gpr_idx),
		.rdata (gpr_rdata)
	);

	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);

	sequence s_rd_req;
		accept && !hwrite;
	endsequence

	sequence s_rd_done;
		!hreadyout ##1 hreadyout;
	endsequence

	chk_read_latency: assert property (
		s_rd_req |=> s_rd_done)
		else $error("read answer not after one wait state");

	chk_unimpl_zero: assert property (
		(state_q == mmb_pkg::BUS_RDWAIT
		&& acc_loc == mmb_pkg::LOC_NONE) |=> hrdata == 32'h00000000)
		else $error("unimplemented location not read as zero");

	chk_bank_write: assert property (
		(wr_en && acc_loc == mmb_pkg::LOC_STATUS)
		|=> bank_select == $past(hwdata[6:5]))
		else $error("bank select not taken from status");

	chk_direct_form: assert property (
		(state_q != mmb_pkg::BUS_IDLE
		&& ofs_q != mmb_pkg::OFS_INDIRECT)
		|-> acc_file == {bank_select, ofs_q})
		else $error("direct address not bank over offset");

	chk_indirect_form: assert property (
		(state_q != mmb_pkg::BUS_IDLE
		&& ofs_q == mmb_pkg::OFS_INDIRECT)
		|-> acc_file[7:0] == file_ptr_q)
		else $error("indirect address not from pointer");

	chk_mirror_counter: assert property (
		(state_q == mmb_pkg::BUS_RDWAIT
		&& acc_loc == mmb_pkg::LOC_PC_LOW && !bad_q)
		|=> hrdata[7:0] == $past(pc_q[7:0]))
		else $error("mirrored counter byte differs");

	chk_prog_read: assert property (
		(state_q == mmb_pkg::BUS_RDWAIT
		&& acc_loc == mmb_pkg::LOC_PRD_LO && !bad_q)
		|=> hrdata[7:0] == $past(prd_q[7:0]))
		else $error("program word not read back");

	chk_fetch_free: assert property (
		(core_step && !core_irq_take && !pc_load
		&& state_q != mmb_pkg::BUS_IDLE)
		|=> fetch_addr != $past(fetch_addr))
		else $error("fetch held up by data access");

endmodule
`default_nettype wire

// [dv/test_mmb_bank_decoder.sv]
// Purpose: Self-checking bench of the banked register map and program counter
// Assumes: Single word AHB-Lite transfers; byte address is four times offset
// Notes:   Uses the smaller program store so the fetch wraparound shows
`timescale 1ns/1ps
`default_nettype none
module test_mmb_bank_decoder;
	localparam int PW  = 4096;
	localparam int TMO = 50;

	typedef struct packed {
		logic [7:0] st;
		logic [6:0] ofs;
		logic       wr;
		logic [7:0] dat;
	} mmb_row_t;

	logic        hclk;
	logic        hresetn;
	logic        hsel;
	logic [31:0] haddr;
	logic [1:0]  htrans;
	logic        hwrite;
	logic [2:0]  hsize;
	logic [31:0] hwdata;
	logic        hreadyout;
	logic [31:0] hrdata;
	logic        hresp;
	logic        core_step;
	logic        core_irq_take;
	logic [12:0] fetch_addr;
	logic [13:0] fetch_word;
	logic [13:0] instr_q;
	logic [12:0] prog_rd_addr;
	logic [13:0] prog_rd_word;
	logic [1:0]  bank_select;
	int          n_mismatch;
	int          samples_checked;
	logic [31:0] rd;
	logic [13:0] w;

	// Status value, offset, write or read, data written or expected
	mmb_row_t rows [0:21] = '{
		'{8'h00, 7'h20, 1'b1, 8'ha1}, '{8'h20, 7'h20, 1'b1, 8'hb2},
		'{8'h40, 7'h20, 1'b1, 8'hc3}, '{8'h60, 7'h70, 1'b1, 8'hd4},
		'{8'h00, 7'h7f, 1'b1, 8'he5}, '{8'h00, 7'h20, 1'b0, 8'ha1},
		'{8'h20, 7'h20, 1'b0, 8'hb2}, '{8'h40, 7'h20, 1'b0, 8'hc3},
		'{8'h00, 7'h70, 1'b0, 8'hd4}, '{8'h60, 7'h7f, 1'b0, 8'he5},
		'{8'h60, 7'h04, 1'b1, 8'ha1}, '{8'h00, 7'h04, 1'b0, 8'ha1},
		'{8'h40, 7'h0a, 1'b1, 8'h0f}, '{8'h20, 7'h0a, 1'b0, 8'h0f},
		'{8'h00, 7'h00, 1'b1, 8'h77}, '{8'h20, 7'h21, 1'b0, 8'h77},
		'{8'h00, 7'h04, 1'b1, 8'h20}, '{8'h40, 7'h00, 1'b0, 8'ha1},
		'{8'h80, 7'h00, 1'b0, 8'hc3}, '{8'h20, 7'h05, 1'b0, 8'h00},
		'{8'h20, 7'h0c, 1'b0, 8'h00}, '{8'h00, 7'h01, 1'b0, 8'h00}
	};

	// Store models answer combinationally, as a real array read would
	assign fetch_word   = {1'b0, fetch_addr} ^ 14'h1234;
	assign prog_rd_word = {1'b0, prog_rd_addr} ^ 14'h2a5a;

	mmb_bank_decoder #(
		.PROG_WORDS(PW)
	) mmb_bank_decoder_i (
		.hclk         (hclk),
		.hresetn      (hresetn),
		.hsel         (hsel),
		.haddr        (haddr),
		.htrans       (htrans),
		.hwrite       (hwrite),
		.hsize        (hsize),
		.hwdata       (hwdata),
		.hready       (hreadyout),
		.hreadyout    (hreadyout),
		.hrdata       (hrdata),
		.hresp        (hresp),
		.core_step    (core_step),
		.core_irq_take(core_irq_take),
		.fetch_addr   (fetch_addr),
		.fetch_word   (fetch_word),
		.instr_q      (instr_q),
		.prog_rd_addr (prog_rd_addr),
		.prog_rd_word (prog_rd_word),
		.bank_select  (bank_select)
	);

	initial begin
		hclk = 1'b0;
		forever #12.5 hclk = ~hclk;
	end

	function automatic logic [31:0] fa(input logic [6:0] o);
		return {23'h0, o, 2'h0};
	endfunction

	task automatic check_data(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic check_pin(input logic [13:0] got, input logic [13:0] exp);
		samples_checked++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	task automatic give_verdict;
		if (n_mismatch == 0 && samples_checked > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	// Inputs only move after rising edges, so the level at the falling
	// edge is what the next rising edge samples
	task automatic wait_ready;
		int n;
		n = 0;
		do begin
			@(negedge hclk);
			n++;
		end while (hreadyout !== 1'b1 && n < TMO);
		if (hreadyout !== 1'b1) begin
			n_mismatch++;
			give_verdict();
		end
	endtask

	task automatic bus(input logic wr, input logic [31:0] a, input logic [7:0] d,
		output logic [31:0] q);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		haddr  <= a;
		hwrite <= wr;
		hsize  <= mmb_pkg::HSIZE_WORD;
		wait_ready();
		@(posedge hclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= {24'h0, d};
		wait_ready();
		q = hrdata;
		check_data({31'h0, hresp}, {31'h0, mmb_pkg::HRESP_OKAY});
		@(posedge hclk);
	endtask

	initial begin
		hresetn       = 1'b0;
		hsel          = 1'b0;
		haddr         = 32'h0;
		htrans        = 2'h0;
		hwrite        = 1'b0;
		hsize         = mmb_pkg::HSIZE_WORD;
		hwdata        = 32'h0;
		core_step     = 1'b0;
		core_irq_take = 1'b0;
		n_mismatch    = 0;
		samples_checked = 0;
		repeat (3) @(posedge hclk);
		@(negedge hclk);
		check_pin({1'b0, fetch_addr}, 14'h0000);
		check_pin({12'h0, bank_select}, 14'h0000);
		check_data(hrdata, 32'h0);
		@(posedge hclk);
		hresetn <= 1'b1;
		foreach (rows[i]) begin
			bus(1'b1, fa(mmb_pkg::OFS_STATUS), rows[i].st, rd);
			bus(rows[i].wr, fa(rows[i].ofs), rows[i].dat, rd);
			check_pin({12'h0, bank_select}, {12'h0, rows[i].st[6:5]});
			if (!rows[i].wr)
				check_data(rd, {24'h0, rows[i].dat});
		end
		// Address bits above the bank span must not reach any register
		bus(1'b1, 32'h200 | fa(mmb_pkg::OFS_FILE_PTR), 8'h55, rd);
		bus(1'b0, fa(mmb_pkg::OFS_FILE_PTR), 8'h00, rd);
		check_data(rd, 32'h20);
		bus(1'b0, 32'h200 | fa(7'h20), 8'h00, rd);
		check_data(rd, 32'h0);
		check_pin({1'b0, fetch_addr}, 14'h0000);
		core_step <= 1'b1;
		repeat (3) @(posedge hclk);
		core_step <= 1'b0;
		@(posedge hclk);
		check_pin({1'b0, fetch_addr}, 14'h0003);
		@(posedge hclk);
		check_pin(instr_q, 14'h0003 ^ 14'h1234);
		core_irq_take <= 1'b1;
		@(posedge hclk);
		core_irq_take <= 1'b0;
		@(posedge hclk);
		check_pin({1'b0, fetch_addr}, 14'h0004);
		bus(1'b1, fa(mmb_pkg::OFS_PC_LATCH), 8'h1f, rd);
		bus(1'b1, fa(mmb_pkg::OFS_PC_LOW), 8'hff, rd);
		bus(1'b0, fa(mmb_pkg::OFS_PC_LOW), 8'h00, rd);
		check_data(rd, 32'hff);
		check_pin({1'b0, fetch_addr}, 14'h0fff);
		core_step <= 1'b1;
		@(posedge hclk);
		core_step <= 1'b0;
		@(posedge hclk);
		check_pin({1'b0, fetch_addr}, 14'h0000);
		bus(1'b1, fa(mmb_pkg::OFS_STATUS), 8'h40, rd);
		bus(1'b1, fa(mmb_pkg::OFS_PRA_LO), 8'h34, rd);
		bus(1'b1, fa(mmb_pkg::OFS_PRA_HI), 8'h01, rd);
		// Read-back word trails its address by one cycle
		repeat (2) @(posedge hclk);
		check_pin({1'b0, prog_rd_addr}, 14'h0134);
		w = 14'h0134 ^ 14'h2a5a;
		bus(1'b0, fa(mmb_pkg::OFS_PRD_LO), 8'h00, rd);
		check_data(rd, {24'h0, w[7:0]});
		bus(1'b0, fa(mmb_pkg::OFS_PRD_HI), 8'h00, rd);
		check_data(rd, {26'h0, w[13:8]});
		core_step <= 1'b1;
		repeat (2) @(posedge hclk);
		hresetn <= 1'b0;
		core_step <= 1'b0;
		@(negedge hclk);
		check_pin({1'b0, fetch_addr}, 14'h0000);
		check_pin({12'h0, bank_select}, 14'h0000);
		@(posedge hclk);
		hresetn <= 1'b1;
		@(posedge hclk);
		give_verdict();
	end
endmodule
`default_nettype wire
